// File: fcf_consts.svh
// constants for the fault capture and flag logic
// What this block does
// RULE1: status compare ignores secondary enable and command
// RULE2: status flag released when primary off or masked
// RULE3: status flag low if unmasked drain below threshold
// RULE4: fault flag low on unmasked fault, enables, select high
// RULE5: fault flag released when primary enable or select low
// RULE6: shorted when on, ground or open when off
// RULE7: diagnostics off while either enable is low
// RULE8: compare continuously, capture only at timer expiry
// RULE9: enables rising together arm all blanking timers
// RULE10: command change starts blanking, capture at expiry
// RULE11: compare change starts filter, capture at expiry
// RULE12: invalid frame delivers no data to registers
// RULE13: latch holds first fault until valid frame
// RULE14: select fall loads codes, releases fault flag
// RULE15: select rise re-arms latches only after valid frame
// RULE16: persisting fault recaptured after re-arm
// RULE17: primary enable high-low-high clears all latches
// RULE18: no latch update while a channel timer runs
// RULE19: auto-retry short turns gate off until retry
// RULE20: latch-off short holds gate off until toggled
// RULE21: auto-retry is default, resumes if still commanded
// RULE22: one global refresh timer, ten and forty taps
// RULE23: codes zero none, three distinct faults, reset zero
`ifndef FCF_CONSTS_SVH
`define FCF_CONSTS_SVH

`define FCF_NCH            6
`define FCF_FRAME_BITS     5'h10
`define FCF_CLK_PERIOD_NS  10
`define FCF_TICK_NS        1000
`define FCF_TICK_CYC       (`FCF_TICK_NS / `FCF_CLK_PERIOD_NS)
`define FCF_T_BL_ON_US     16'h0014
`define FCF_T_BL_OFF_US    16'h001E
`define FCF_T_FF_US        16'h000A
`define FCF_T_REFR_SHORT_MS 10
`define FCF_T_REFR_LONG_MS  40
`define FCF_US_PER_MS      1000
`define FCF_CODE_RST       2'h0
// synchroniser reset: select idles high, every other pin low
`define FCF_PIN_RST        29'h4000000

`endif

// File: fcf_pkg.sv
// types shared by the fault capture and flag logic
package fcf_pkg;

  typedef enum logic [1:0] {
    FCF_CODE_NONE  = 2'h0,
    FCF_CODE_OPEN  = 2'h1,
    FCF_CODE_GND   = 2'h2,
    FCF_CODE_SHORT = 2'h3
  } fcf_code_t;

  typedef enum logic [2:0] {
    FCF_TMR_IDLE  = 3'h1,
    FCF_TMR_BLANK = 3'h2,
    FCF_TMR_FILT  = 3'h4
  } fcf_tmr_t;

endpackage

// File: fcf_chan_if.sv
// signals between the top and one fault channel
`timescale 1ns/10ps
interface fcf_chan_if;
  import fcf_pkg::*;
  logic      tick;
  logic      en1;
  logic      en_both;
  logic      arm_all;
  logic      cmd;
  logic      below_ol;
  logic      below_sg;
  logic      above_short;
  logic      latch_off;
  logic      retry_tick;
  logic      rearm;
  fcf_code_t code;
  logic      gate;
  logic      retry_wait;

  modport chan (
    input  tick, en1, en_both, arm_all, cmd, below_ol, below_sg,
    input  above_short, latch_off, retry_tick, rearm,
    output code, gate, retry_wait
  );
  modport top (
    output tick, en1, en_both, arm_all, cmd, below_ol, below_sg,
    output above_short, latch_off, retry_tick, rearm,
    input  code, gate, retry_wait
  );
endinterface

// File: fcf_chan.sv
// one channel: timers, fault latch and gate control
`timescale 1ns/10ps
`include "fcf_consts.svh"
module fcf_chan (
  // clock and reset
  input  wire logic i_clk,
  input  wire logic i_arst_n,
  // link to the top
  fcf_chan_if.chan  ch
);
  import fcf_pkg::*;

  fcf_tmr_t    tmr_q;
  logic [15:0] cnt_q;
  fcf_code_t   cmp_now;
  fcf_code_t   cmp_q;
  fcf_code_t   det_q;
  fcf_code_t   code_q;
  logic        cmd_q;
  logic        hold_q;
  logic        gate_q;
  logic        diag_on;
  logic        cmd_chg;
  logic        retry_go;
  logic        blank_go;
  logic        expire;
  logic        cap;

  // references chosen by commanded state
  always_comb begin
    cmp_now = FCF_CODE_NONE;                             // [RULE6]
    if (ch.cmd) begin
      if (ch.above_short) cmp_now = FCF_CODE_SHORT;
    end else if (ch.below_sg) begin
      cmp_now = FCF_CODE_GND;
    end else if (ch.below_ol) begin
      cmp_now = FCF_CODE_OPEN;
    end
  end

  assign diag_on  = ch.en_both & ~hold_q;                // [RULE7]
  assign cmd_chg  = ch.en_both & (ch.cmd != cmd_q);
  assign retry_go = hold_q & ~ch.latch_off & ch.retry_tick; // [RULE19]
  assign blank_go = ch.arm_all | cmd_chg | retry_go;     // [RULE9] [RULE10]
  assign expire   = (tmr_q != FCF_TMR_IDLE) && (cnt_q == 16'h0000) && ch.tick;
  assign cap      = expire & diag_on;                    // [RULE8]

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      cmd_q <= 1'b0;
      cmp_q <= FCF_CODE_NONE;
    end else begin
      cmd_q <= ch.cmd;
      cmp_q <= ch.en_both ? cmp_now : FCF_CODE_NONE;
    end
  end

  // blanking and filter timer
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      tmr_q <= FCF_TMR_IDLE;
      cnt_q <= 16'h0000;
    end else if (!ch.en_both) begin
      tmr_q <= FCF_TMR_IDLE;                             // [RULE7]
      cnt_q <= 16'h0000;
    end else if (blank_go) begin
      tmr_q <= FCF_TMR_BLANK;                            // [RULE10]
      cnt_q <= ch.cmd ? `FCF_T_BL_ON_US : `FCF_T_BL_OFF_US;
    end else if (tmr_q != FCF_TMR_BLANK && diag_on && cmp_now != cmp_q) begin
      tmr_q <= FCF_TMR_FILT;                             // [RULE11]
      cnt_q <= `FCF_T_FF_US;
    end else if (expire) begin
      tmr_q <= FCF_TMR_IDLE;
    end else if (tmr_q != FCF_TMR_IDLE && ch.tick) begin
      cnt_q <= cnt_q - 16'h0001;
    end
  end

  // live fault bits, refreshed only at expiry
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      det_q <= FCF_CODE_NONE;
    end else if (!ch.en_both) begin
      det_q <= FCF_CODE_NONE;
    end else if (cap) begin
      det_q <= cmp_now;                                  // [RULE18]
    end
  end

  // fault latch; a fault capture wins over a re-arm in the same cycle
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      code_q <= fcf_code_t'(`FCF_CODE_RST);              // [RULE23]
    end else if (!ch.en1) begin
      code_q <= FCF_CODE_NONE;                           // [RULE17]
    end else if (cap && cmp_now != FCF_CODE_NONE &&
                 (code_q == FCF_CODE_NONE || ch.rearm)) begin // [RULE13]
      code_q <= cmp_now;                                 // [RULE10] [RULE11]
    end else if (ch.rearm) begin
      code_q <= det_q;                                   // [RULE15] [RULE16]
    end
  end

  // shorted load shutdown and gate
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      hold_q <= 1'b0;
      gate_q <= 1'b0;
    end else begin
      if (!ch.en_both || !ch.cmd) begin
        hold_q <= 1'b0;                                  // [RULE20]
      end else if (cap && cmp_now == FCF_CODE_SHORT) begin
        hold_q <= 1'b1;                                  // [RULE19]
      end else if (retry_go) begin
        hold_q <= 1'b0;                                  // [RULE21]
      end
      gate_q <= ch.en_both & ch.cmd & ~hold_q;
    end
  end

  assign ch.code       = code_q;
  assign ch.gate       = gate_q;
  assign ch.retry_wait = hold_q & ~ch.latch_off;         // [RULE22]

  a_diag_off: assert property (  // [RULE7]
    @(posedge i_clk) disable iff (!i_arst_n)
    !ch.en_both |=> tmr_q == FCF_TMR_IDLE)
    else $error("timer running with an enable low");
  a_blank_start: assert property (  // [RULE10]
    @(posedge i_clk) disable iff (!i_arst_n)
    cmd_chg |=> tmr_q == FCF_TMR_BLANK && cnt_q != 16'h0000)
    else $error("command change did not start blanking");
  a_latch_hold: assert property (  // [RULE13]
    @(posedge i_clk) disable iff (!i_arst_n)
    code_q != FCF_CODE_NONE && !ch.rearm && ch.en1
    |=> code_q == $past(code_q))
    else $error("latched code changed without re-arm");
  a_busy_hold: assert property (  // [RULE18]
    @(posedge i_clk) disable iff (!i_arst_n)
    ch.en_both && tmr_q != FCF_TMR_IDLE && !expire
    |=> $stable(det_q))
    else $error("fault bits changed while a timer ran");
  a_short_off: assert property (  // [RULE19]
    @(posedge i_clk) disable iff (!i_arst_n)
    cap && cmp_now == FCF_CODE_SHORT && ch.cmd ##1 ch.cmd && ch.en_both
    |=> !gate_q)
    else $error("gate still on after shorted load");
  a_en1_clear: assert property (  // [RULE17]
    @(posedge i_clk) disable iff (!i_arst_n)
    !ch.en1 |=> code_q == FCF_CODE_NONE)
    else $error("latch not cleared by primary enable low");
endmodule

// File: fcf_top.sv
// six-channel fault capture, flags and serial readback
`timescale 1ns/10ps
`include "fcf_consts.svh"
module fcf_top #(
  parameter int unsigned REFR_SHORT_TICKS =
    `FCF_T_REFR_SHORT_MS * `FCF_US_PER_MS,
  parameter int unsigned REFR_LONG_TICKS  =
    `FCF_T_REFR_LONG_MS * `FCF_US_PER_MS
) (
  // clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_arst_n,
  // enables and channel commands (pins)
  input  wire logic       i_enable_primary,
  input  wire logic       i_enable_secondary,
  input  wire logic [5:0] i_parallel_cmd_in,
  // drain comparator results (asynchronous)
  input  wire logic [5:0] i_below_open_load_threshold,
  input  wire logic [5:0] i_below_short_gnd_threshold,
  input  wire logic [5:0] i_above_short_threshold_ref,
  // serial link pins
  input  wire logic       i_chip_select_n,
  input  wire logic       i_spi_sclk,
  input  wire logic       i_spi_mosi,
  output logic            o_spi_miso,
  // configuration from the register file
  input  wire logic [5:0] i_serial_cmd_bit,
  input  wire logic [5:0] i_flag_mask,
  input  wire logic [5:0] i_latch_off_mode,
  input  wire logic [1:0] i_refresh_long_sel,
  // received word for the register file
  output logic [15:0]     o_rx_word,
  output logic            o_rx_word_valid,
  // gate drive
  output logic [5:0]      o_gate_drive,
  // open-drain flags
  output logic            o_drain_status_flag_n_o,
  output logic            o_drain_status_flag_n_oe,
  output logic            o_fault_flag_n_o,
  output logic            o_fault_flag_n_oe
);
  import fcf_pkg::*;

  localparam int PW = 29;

  logic [PW-1:0] pin_s1_q;
  logic [PW-1:0] pin_s2_q;
  logic          en1;
  logic          en2;
  logic          cs_n;
  logic          sclk;
  logic          mosi;
  logic [5:0]    pin_cmd;
  logic [5:0]    below_ol;
  logic [5:0]    below_sg;
  logic [5:0]    above_sh;
  logic          sclk_d_q;
  logic          cs_d_q;
  logic          en_both_q;
  logic          en_both;
  logic          cs_fall;
  logic          cs_rise;
  logic          sclk_rise;
  logic          sclk_fall;
  logic [6:0]    div_q;
  logic          tick_q;
  logic          miso_nxt_q;
  logic [15:0]   shift_q;
  logic [4:0]    bits_q;
  logic          frame_ok;
  logic          rearm_q;
  logic [15:0]   rsub_q;
  logic [15:0]   rlng_q;
  logic          rshort_q;
  logic          rlong_q;
  logic          any_wait;
  logic [11:0]   codes;
  logic [5:0]    faulted;
  logic [5:0]    gates;
  logic [5:0]    waits;
  logic          stat_low;
  logic          flt_low;

  // two-flop synchroniser for every pin
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      // select resets to its idle level so no false edge follows reset
      pin_s1_q <= `FCF_PIN_RST;
      pin_s2_q <= `FCF_PIN_RST;
    end else begin
      pin_s1_q <= {i_enable_primary, i_enable_secondary, i_chip_select_n,
                   i_spi_sclk, i_spi_mosi, i_parallel_cmd_in,
                   i_below_open_load_threshold,
                   i_below_short_gnd_threshold,
                   i_above_short_threshold_ref};
      pin_s2_q <= pin_s1_q;
    end
  end

  assign {en1, en2, cs_n, sclk, mosi, pin_cmd, below_ol, below_sg,
          above_sh} = pin_s2_q;
  assign en_both = en1 & en2;

  // edge finders on synchronised levels
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      sclk_d_q  <= 1'b0;
      cs_d_q    <= 1'b1;
      en_both_q <= 1'b0;
    end else begin
      sclk_d_q  <= sclk;
      cs_d_q    <= cs_n;
      en_both_q <= en_both;
    end
  end

  assign cs_fall   = cs_d_q & ~cs_n;
  assign cs_rise   = ~cs_d_q & cs_n;
  assign sclk_rise = ~sclk_d_q & sclk & ~cs_n;
  assign sclk_fall = sclk_d_q & ~sclk & ~cs_n;

  // microsecond tick for all timers
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      div_q  <= 7'h00;
      tick_q <= 1'b0;
    end else if (div_q == 7'(`FCF_TICK_CYC - 1)) begin
      div_q  <= 7'h00;
      tick_q <= 1'b1;
    end else begin
      div_q  <= div_q + 7'h01;
      tick_q <= 1'b0;
    end
  end

  // serial shift register and frame check
  assign frame_ok = (bits_q == `FCF_FRAME_BITS);

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      shift_q <= 16'h0000;
      bits_q  <= 5'h00;
    end else if (cs_fall) begin
      shift_q <= {4'h0, codes};                          // [RULE14]
      bits_q  <= 5'h00;
    end else if (sclk_rise) begin
      shift_q <= {shift_q[14:0], mosi};
      if (bits_q != 5'h1F) bits_q <= bits_q + 5'h01;
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      miso_nxt_q <= 1'b0;
      o_spi_miso <= 1'b0;
    end else if (cs_fall) begin
      miso_nxt_q <= 1'b0;
      o_spi_miso <= 1'b0;
    end else if (sclk_rise) begin
      // keep the msb before it is shifted out, so bit 15 goes first
      miso_nxt_q <= shift_q[15];                         // [RULE14]
    end else if (sclk_fall) begin
      o_spi_miso <= miso_nxt_q;
    end
  end

  // only a frame of exactly sixteen clocks is delivered
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_rx_word       <= 16'h0000;
      o_rx_word_valid <= 1'b0;
      rearm_q         <= 1'b0;
    end else begin
      o_rx_word_valid <= cs_rise & frame_ok;             // [RULE12]
      rearm_q         <= cs_rise & frame_ok;             // [RULE15]
      if (cs_rise && frame_ok) o_rx_word <= shift_q;
    end
  end

  // global refresh timer with short and long taps
  assign any_wait = |waits;

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rsub_q   <= 16'h0000;
      rlng_q   <= 16'h0000;
      rshort_q <= 1'b0;
      rlong_q  <= 1'b0;
    end else if (!any_wait) begin
      rsub_q   <= 16'h0000;                              // [RULE22]
      rlng_q   <= 16'h0000;
      rshort_q <= 1'b0;
      rlong_q  <= 1'b0;
    end else begin
      rshort_q <= 1'b0;
      rlong_q  <= 1'b0;
      if (tick_q) begin
        if (rsub_q == 16'(REFR_SHORT_TICKS - 1)) begin
          rsub_q   <= 16'h0000;
          rshort_q <= 1'b1;
        end else begin
          rsub_q <= rsub_q + 16'h0001;
        end
        if (rlng_q == 16'(REFR_LONG_TICKS - 1)) begin
          rlng_q  <= 16'h0000;
          rlong_q <= 1'b1;
        end else begin
          rlng_q <= rlng_q + 16'h0001;
        end
      end
    end
  end

  // the six channels
  fcf_chan_if ch_if [`FCF_NCH] ();

  for (genvar g = 0; g < `FCF_NCH; g++) begin : g_ch
    assign ch_if[g].tick        = tick_q;
    assign ch_if[g].en1         = en1;
    assign ch_if[g].en_both     = en_both;
    assign ch_if[g].arm_all     = en_both & ~en_both_q;  // [RULE9]
    assign ch_if[g].cmd         = pin_cmd[g] | i_serial_cmd_bit[g];
    assign ch_if[g].below_ol    = below_ol[g];
    assign ch_if[g].below_sg    = below_sg[g];
    assign ch_if[g].above_short = above_sh[g];
    assign ch_if[g].latch_off   = i_latch_off_mode[g];
    assign ch_if[g].retry_tick  =
      i_refresh_long_sel[g / 3] ? rlong_q : rshort_q;
    assign ch_if[g].rearm       = rearm_q;
    assign codes[2*g +: 2]      = ch_if[g].code;
    assign faulted[g]           = ch_if[g].code != FCF_CODE_NONE;
    assign gates[g]             = ch_if[g].gate;
    assign waits[g]             = ch_if[g].retry_wait;

    fcf_chan u_chan (
      .i_clk    (i_clk),
      .i_arst_n (i_arst_n),
      .ch       (ch_if[g])
    );
  end

  // flag outputs
  assign stat_low = en1 & |(~i_flag_mask & below_ol);    // [RULE1] [RULE3]
  assign flt_low  = en1 & en2 & cs_n & |(~i_flag_mask & faulted); // [RULE4]

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_drain_status_flag_n_o  <= 1'b1;
      o_drain_status_flag_n_oe <= 1'b0;
    end else begin
      o_drain_status_flag_n_o  <= ~stat_low;             // [RULE2]
      o_drain_status_flag_n_oe <= stat_low;
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_fault_flag_n_o  <= 1'b1;
      o_fault_flag_n_oe <= 1'b0;
    end else begin
      o_fault_flag_n_o  <= ~flt_low;                     // [RULE5]
      o_fault_flag_n_oe <= flt_low;
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_gate_drive <= 6'h00;
    end else begin
      o_gate_drive <= gates;
    end
  end

  a_drain_status_flag_n_release: assert property (  // [RULE2]
    @(posedge i_clk) disable iff (!i_arst_n)
    (!en1 || &i_flag_mask) |=> !o_drain_status_flag_n_oe)
    else $error("status flag driven while disabled");
  a_drain_status_flag_n_drive: assert property (  // [RULE3]
    @(posedge i_clk) disable iff (!i_arst_n)
    en1 && |(~i_flag_mask & below_ol)
    |=> o_drain_status_flag_n_oe && !o_drain_status_flag_n_o)
    else $error("status flag not driven low");
  a_flt_set: assert property (  // [RULE4]
    @(posedge i_clk) disable iff (!i_arst_n)
    en1 && en2 && cs_n && |(~i_flag_mask & faulted)
    |=> o_fault_flag_n_oe)
    else $error("fault flag not driven on fault");
  a_flt_release: assert property (  // [RULE5]
    @(posedge i_clk) disable iff (!i_arst_n)
    (!en1 || !cs_n) |=> !o_fault_flag_n_oe)
    else $error("fault flag driven with select or enable low");
  a_load_codes: assert property (  // [RULE14]
    @(posedge i_clk) disable iff (!i_arst_n)
    cs_fall |=> shift_q == {4'h0, $past(codes)})
    else $error("codes not loaded at select fall");
  a_bad_frame: assert property (  // [RULE12]
    @(posedge i_clk) disable iff (!i_arst_n)
    cs_rise && !frame_ok |=> !o_rx_word_valid && !rearm_q)
    else $error("invalid frame delivered or re-armed");
  a_good_frame: assert property (  // [RULE15]
    @(posedge i_clk) disable iff (!i_arst_n)
    cs_rise && frame_ok |=> rearm_q ##1 !rearm_q)
    else $error("valid frame did not re-arm once");
  a_refresh_idle: assert property (  // [RULE22]
    @(posedge i_clk) disable iff (!i_arst_n)
    !any_wait |=> rsub_q == 16'h0000 && !rshort_q && !rlong_q)
    else $error("refresh timer ran with no channel waiting");
endmodule

// File: fcf_host.sv
// host model: serial frames and pulled-up open-drain flag lines
`timescale 1ns/10ps
module fcf_host (
  // from the device
  input  wire logic i_stat_oe,
  input  wire logic i_fault_oe,
  input  wire logic i_miso,
  // serial link and resolved flag levels
  output logic      o_cs_n,
  output logic      o_sclk,
  output logic      o_mosi,
  output logic      o_stat_n,
  output logic      o_fault_n
);
  // pull-up wins whenever the device does not pull low
  assign o_stat_n  = i_stat_oe ? 1'b0 : 1'b1;
  assign o_fault_n = i_fault_oe ? 1'b0 : 1'b1;

  initial begin
    o_cs_n = 1'b1;
    o_sclk = 1'b0;
    o_mosi = 1'b0;
  end

  // n clock pulses, msb first; n other than 16 makes a bad frame
  task automatic frame(input int n, input logic [15:0] wr,
                       output logic [15:0] rd);
    rd = 16'h0000;
    o_cs_n = 1'b0;
    #150;
    // 125 ns link clock; miso settles well within half a period
    for (int i = 0; i < n; i++) begin
      o_mosi = wr[15 - (i % 16)];
      #62.5 o_sclk = 1'b1;
      if (i > 0) rd = {rd[14:0], i_miso};
      #62.5 o_sclk = 1'b0;
    end
    #62.5 rd = {rd[14:0], i_miso};
    o_cs_n = 1'b1;
    #300;
  endtask
endmodule

// File: fcf_top_test.sv
// self-checking bench for the fault capture and flag logic
`timescale 1ns/10ps
module fcf_top_test;
  import fcf_pkg::*;
  logic        i_clk, i_arst_n, en1, en2;
  logic [5:0]  cmd, b_ol, b_sg, a_sh, scmd, mask, gate, loff;
  logic [1:0]  rsel;
  logic        cs_n, sclk, mosi, miso, stat_oe, flt_oe, rx_v;
  logic        stat_n, flt_n, stat_o, flt_o;
  logic [15:0] rx_word, rd;
  int          errors, n_compared, n_valid, cycles;

  fcf_top #(.REFR_SHORT_TICKS(20), .REFR_LONG_TICKS(80)) fcf_top_inst (
    .i_clk(i_clk), .i_arst_n(i_arst_n),
    .i_enable_primary(en1), .i_enable_secondary(en2),
    .i_parallel_cmd_in(cmd),
    .i_below_open_load_threshold(b_ol),
    .i_below_short_gnd_threshold(b_sg),
    .i_above_short_threshold_ref(a_sh),
    .i_chip_select_n(cs_n), .i_spi_sclk(sclk), .i_spi_mosi(mosi),
    .o_spi_miso(miso), .i_serial_cmd_bit(scmd), .i_flag_mask(mask),
    .i_latch_off_mode(loff), .i_refresh_long_sel(rsel),
    .o_rx_word(rx_word), .o_rx_word_valid(rx_v), .o_gate_drive(gate),
    .o_drain_status_flag_n_o(stat_o), .o_drain_status_flag_n_oe(stat_oe),
    .o_fault_flag_n_o(flt_o), .o_fault_flag_n_oe(flt_oe));

  fcf_host fcf_host_inst (
    .i_stat_oe(stat_oe), .i_fault_oe(flt_oe), .i_miso(miso),
    .o_cs_n(cs_n), .o_sclk(sclk), .o_mosi(mosi),
    .o_stat_n(stat_n), .o_fault_n(flt_n));

  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end

  always @(negedge i_clk) begin
    if (rx_v === 1'b1)
      n_valid++;
    cycles++;
    if (cycles == 50000) begin
      errors++;
      summarize();
    end
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(negedge i_clk);
  endtask

  task automatic summarize;
    $display("errors %0d compared %0d", errors, n_compared);
    if (errors == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic t_status;
    en1 = 1'b1;
    cmd = 6'h01;
    b_ol = 6'h01;
    wait_cyc(10);
    check({14'h0000, stat_n, flt_n}, 16'h0001);
    check({14'h0000, stat_o, stat_oe}, 16'h0001);
    mask = 6'h3F;
    wait_cyc(10);
    check({15'h0000, stat_n}, 16'h0001);
    mask = 6'h00;
    b_ol = 6'h00;
    wait_cyc(10);
    check({15'h0000, stat_n}, 16'h0001);
    b_ol = 6'h01;
    en1 = 1'b0;
    cmd = 6'h00;
    wait_cyc(10);
    check({15'h0000, stat_n}, 16'h0001);
    b_ol = 6'h00;
    wait_cyc(10);
  endtask

  // open load on ch1 after both enables rise together
  task automatic t_open;
    b_ol = 6'h02;
    en1 = 1'b1;
    en2 = 1'b1;
    wait_cyc(2500);
    check({15'h0000, flt_n}, 16'h0001);
    wait_cyc(800);
    check({15'h0000, flt_n}, 16'h0000);
    check({14'h0000, flt_o, flt_oe}, 16'h0001);
    fork
      fcf_host_inst.frame(16, 16'hA5C3, rd);
      begin
        #1000 check({15'h0000, flt_n}, 16'h0001);
      end
    join
    check(rd, 16'h0004);
    check(rx_word, 16'hA5C3);
    wait_cyc(20);
    check({15'h0000, flt_n}, 16'h0000);
  endtask

  task automatic t_bad_frame;
    int nv;
    b_sg = 6'h02;
    wait_cyc(1200);
    nv = n_valid;
    fcf_host_inst.frame(15, 16'h1234, rd);
    wait_cyc(10);
    check(n_valid[15:0], nv[15:0]);
    check(rx_word, 16'hA5C3);
    check({15'h0000, flt_n}, 16'h0000);
    fcf_host_inst.frame(16, 16'h0F0F, rd);
    check(rd, 16'h0004);
    fcf_host_inst.frame(16, 16'h0F0F, rd);
    check(rd, 16'h0008);
    check(n_valid[15:0], nv[15:0] + 16'h0002);
  endtask

  task automatic t_rearm;
    en1 = 1'b0;
    wait_cyc(10);
    check({15'h0000, flt_n}, 16'h0001);
    en1 = 1'b1;
    wait_cyc(10);
    fcf_host_inst.frame(16, 16'h0000, rd);
    check(rd, 16'h0000);
    wait_cyc(3500);
    check({15'h0000, flt_n}, 16'h0000);
    b_ol = 6'h00;
    b_sg = 6'h00;
    wait_cyc(1500);
    fcf_host_inst.frame(16, 16'h0000, rd);
    check(rd, 16'h0008);
    fcf_host_inst.frame(16, 16'h0000, rd);
    check(rd, 16'h0000);
  endtask

  // shorted load on ch2 commanded by the serial bit, auto-retry
  task automatic t_short;
    scmd = 6'h04;
    a_sh = 6'h04;
    wait_cyc(10);
    check({10'h000, gate}, 16'h0004);
    wait_cyc(2300);
    check({10'h000, gate}, 16'h0000);
    check({15'h0000, flt_n}, 16'h0000);
    fcf_host_inst.frame(16, 16'h0000, rd);
    check(rd, 16'h0030);
    wait_cyc(1600);
    check({10'h000, gate}, 16'h0004);
    wait_cyc(2100);
    check({10'h000, gate}, 16'h0000);
  endtask

  // long refresh tap, then latch-off on the still shorted ch2
  task automatic t_modes;
    rsel = 2'h1;
    wait_cyc(2500);
    check({10'h000, gate}, 16'h0000);
    wait_cyc(5500);
    check({10'h000, gate}, 16'h0004);
    loff = 6'h04;
    rsel = 2'h0;
    wait_cyc(2300);
    check({10'h000, gate}, 16'h0000);
    wait_cyc(2500);
    check({10'h000, gate}, 16'h0000);
    scmd = 6'h00;
    wait_cyc(10);
    scmd = 6'h04;
    wait_cyc(10);
    check({10'h000, gate}, 16'h0004);
  endtask

  initial begin
    i_arst_n = 1'b0;
    {en1, en2} = 2'b00;
    {cmd, b_ol, b_sg, a_sh, scmd, mask, loff} = 42'h0;
    rsel = 2'h0;
    errors = 0;
    n_compared = 0;
    n_valid = 0;
    cycles = 0;
    wait_cyc(6);
    check({8'h00, stat_n, flt_n, gate}, 16'h00C0);
    i_arst_n = 1'b1;
    wait_cyc(5);
    t_status();
    t_open();
    t_bad_frame();
    t_rearm();
    t_short();
    t_modes();
    summarize();
  end
endmodule
